//--- ssl_top.v
// clock reference selection, input lock status, serial routing and box link state
// assumes receivers give lock levels and frame-rate strobes as asynchronous pins,
// and the serial/optical transmit data come from logic on clk_i
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "ssl_regs.vh"
module ssl_top #(
   parameter GATE_CYC = `SSL_GATE_CYC,
   parameter RW = 8
)(
   input wire clk_i,
   input wire rst_i,
   input wire [`SSL_ADDR_W-1:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   input wire [3:0] in_lock_i,
   input wire [3:0] in_frame_i,
   input wire box_present_i,
   input wire box_loading_i,
   input wire update_failed_i,
   input wire warm_restart_i,
   input wire ser_tx_i,
   input wire opt_tx_i,
   output reg [2:0] clk_ref_o,
   output reg ser_rx_opt_o,
   output reg coax_out_o,
   output reg opt_out_o,
   output reg link_en_o,
   output reg backup_image_o
);
   // synchronised pins
   wire [3:0] lock_s;
   wire [3:0] frame_s;
   wire box_present_s;
   wire box_loading_s;
   wire update_failed_s;

   // software configuration
   reg [`SSL_CTRL_W-1:0] ctrl;
   reg [RW-1:0] play_rate;
   wire auto_mode = ctrl[`SSL_CTRL_AUTO];
   wire [1:0] pref = ctrl[`SSL_CTRL_PREF_HI:`SSL_CTRL_PREF_LO];
   wire disc_cmd = ctrl[`SSL_CTRL_DISC];

   // measured rates, one per candidate
   wire [RW-1:0] rate0;
   wire [RW-1:0] rate1;
   wire [RW-1:0] rate2;
   wire [RW-1:0] rate3;
   reg [RW-1:0] cand_rate [0:3];

   // status state
   reg [2:0] ref_code;
   reg [RW-1:0] ref_rate;
   reg [7:0] lock_stat;
   reg [1:0] link_st;
   reg [1:0] next_link_st;
   reg [1:0] boot_cnt;
   reg boot_done;

   // selection results
   reg [3:0] match;
   reg [3:0] usable;
   reg [2:0] next_ref;
   reg [1:0] idx;
   reg found;
   reg [RW-1:0] diff;
   integer i;
   integer j;
   integer k;

   ssl_sync2 #(
      .W(11)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({in_lock_i, in_frame_i, box_present_i, box_loading_i, update_failed_i}),
      .q_o({lock_s, frame_s, box_present_s, box_loading_s, update_failed_s})
   );

   // one meter per candidate: word clock, optical, sync connector, serial
   ssl_rate_meter #(
      .GATE_CYC(GATE_CYC),
      .CW(32),
      .RW(RW)
   ) u_rate0 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .lvl_i(frame_s[0]),
      .rate_o(rate0)
   );

   ssl_rate_meter #(
      .GATE_CYC(GATE_CYC),
      .CW(32),
      .RW(RW)
   ) u_rate1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .lvl_i(frame_s[1]),
      .rate_o(rate1)
   );

   ssl_rate_meter #(
      .GATE_CYC(GATE_CYC),
      .CW(32),
      .RW(RW)
   ) u_rate2 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .lvl_i(frame_s[2]),
      .rate_o(rate2)
   );

   ssl_rate_meter #(
      .GATE_CYC(GATE_CYC),
      .CW(32),
      .RW(RW)
   ) u_rate3 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .lvl_i(frame_s[3]), // [R9]
      .rate_o(rate3)
   );

   // rate match against playback; a small tolerance absorbs gate phase jitter
   always @*
   begin
      cand_rate[0] = rate0;
      cand_rate[1] = rate1;
      cand_rate[2] = rate2;
      cand_rate[3] = rate3;
      diff = {RW{1'b0}};
      match = 4'h0;
      for (i = 0; i < 4; i = i + 1)
      begin
         diff = (cand_rate[i] > play_rate) ? cand_rate[i] - play_rate
                                           : play_rate - cand_rate[i];
         match[i] = (diff <= `SSL_RATE_TOL); // [R20]
      end
      usable = lock_s & match; // [R3]
   end

   // scan from the preferred input onward, wrapping, first usable wins
   always @*
   begin
      next_ref = `SSL_REF_MASTER; // [R19]
      found = 1'b0;
      idx = 2'h0;
      for (j = 0; j < 4; j = j + 1)
      begin
         idx = pref + j[1:0];
         if (!found && usable[idx]) // [R2]
         begin
            found = 1'b1;
            next_ref = {1'b0, idx} + 3'h1;
         end
      end
      if (!auto_mode)
         next_ref = `SSL_REF_MASTER; // [R1]
   end

   // link state machine toward the remote box
   always @*
   begin
      next_link_st = link_st;
      case (link_st)
         `SSL_LINK_ERROR:
            if (box_present_s)
               next_link_st = `SSL_LINK_DETECT;
         `SSL_LINK_DETECT:
            if (!box_present_s)
               next_link_st = `SSL_LINK_ERROR; // [R10]
            else if (!box_loading_s)
               next_link_st = `SSL_LINK_CONN; // [R12]
         `SSL_LINK_CONN:
            if (!box_present_s)
               next_link_st = `SSL_LINK_ERROR;
            else if (box_loading_s)
               next_link_st = `SSL_LINK_DETECT; // [R11]
         `SSL_LINK_DISC:
            if (!disc_cmd)
               next_link_st = `SSL_LINK_ERROR;
         default:
            next_link_st = `SSL_LINK_ERROR;
      endcase
      if (disc_cmd)
         next_link_st = `SSL_LINK_DISC; // [R14]
   end

   // register writes land in the very next cycle, no commit step;
   // streaming glitches on change are the software's concern
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl <= `SSL_CTRL_RST;
         play_rate <= `SSL_PLAY_RST;
      end
      else if (wr_i)
      begin
         if (addr_i == `SSL_OFS_CTRL)
            ctrl <= wdata_i[`SSL_CTRL_W-1:0]; // [R15] [R16]
         if (addr_i == `SSL_OFS_PLAY_RATE)
            play_rate <= wdata_i[RW-1:0];
      end
   end

   // status and clock steering
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ref_code <= `SSL_REF_MASTER;
         ref_rate <= {RW{1'b0}};
         lock_stat <= 8'h00;
         link_st <= `SSL_LINK_ERROR;
         clk_ref_o <= `SSL_REF_MASTER;
         link_en_o <= 1'b0;
      end
      else
      begin
         ref_code <= next_ref;
         clk_ref_o <= next_ref;
         ref_rate <= (next_ref == `SSL_REF_MASTER) ? play_rate
                                                  : cand_rate[next_ref[1:0] - 2'h1]; // [R4]
         for (k = 0; k < 4; k = k + 1)
            lock_stat[2*k +: 2] <= !lock_s[k] ? `SSL_ST_NONE
                                  : (match[k] && next_ref == k + 1) ? `SSL_ST_SYNC
                                  : `SSL_ST_LOCK; // [R5]
         link_st <= next_link_st;
         link_en_o <= !disc_cmd; // [R13]
      end
   end

   // serial routing; coaxial copy is unconditional
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ser_rx_opt_o <= 1'b0;
         coax_out_o <= 1'b0;
         opt_out_o <= 1'b0;
      end
      else
      begin
         ser_rx_opt_o <= ctrl[`SSL_CTRL_SER_IN_OPT]; // [R6]
         coax_out_o <= ser_tx_i; // [R7]
         opt_out_o <= ctrl[`SSL_CTRL_SER_OUT_OPT] ? ser_tx_i : opt_tx_i; // [R8]
      end
   end

   // image choice is caught once after a cold reset, when the synchroniser
   // has settled; warm restarts never re-sample, so a freshly written image
   // waits for the next power cycle
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         boot_cnt <= 2'h0;
         boot_done <= 1'b0;
         backup_image_o <= 1'b0;
      end
      else if (!boot_done)
      begin
         boot_cnt <= boot_cnt + 2'h1;
         if (boot_cnt == 2'h2)
         begin
            boot_done <= 1'b1;
            backup_image_o <= update_failed_s; // [R17]
         end
      end
      else if (warm_restart_i)
         backup_image_o <= backup_image_o; // [R18]
   end

   // read port, data stand one cycle after the strobe; unmapped reads zero
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_o <= 32'h0000_0000;
      else if (rd_i)
      begin
         case (addr_i)
            `SSL_OFS_CTRL:
               rdata_o <= {{(32-`SSL_CTRL_W){1'b0}}, ctrl};
            `SSL_OFS_PLAY_RATE:
               rdata_o <= {{(32-RW){1'b0}}, play_rate};
            `SSL_OFS_REF_STAT:
               rdata_o <= {{(24-RW){1'b0}}, ref_rate, 5'h00, ref_code};
            `SSL_OFS_LOCK_STAT:
               rdata_o <= {{22{1'b0}}, link_st, lock_stat}; // [R21]
            `SSL_OFS_SER_RATE:
               rdata_o <= {{(32-RW){1'b0}}, rate3}; // [R9]
            `SSL_OFS_BOOT_STAT:
               rdata_o <= {{30{1'b0}}, boot_done, backup_image_o};
            default:
               rdata_o <= 32'h0000_0000;
         endcase
      end
      else
         rdata_o <= 32'h0000_0000;
   end
endmodule

//--- ssl_regs.vh
// register offsets, field positions, codes and timing for the sync source / link block
// assumes the including files are verilog or systemverilog on a 50 MHz clock
// Operation
// [R1] master or automatic external reference clocking
// [R2] preferred input dead: take next valid
// [R3] candidates: word clock, optical, sync, serial
// [R4] report active reference and its rate
// [R5] per input: none, lock or sync
// [R6] serial receiver from coaxial or optical
// [R7] serial transmitter always drives coaxial out
// [R8] optical option copies serial out optically
// [R9] measure serial input sample rate
// [R10] link error when box absent or unpowered
// [R11] link detected while box firmware loads
// [R12] link connected while communication works
// [R13] disconnect command stops link communication
// [R14] after disconnect box runs, status disconnected
// [R15] configuration writes act at once
// [R16] software avoids changes during streaming
// [R17] failed update selects backup image
// [R18] new image only after power cycle
// [R19] no valid input: internal master clock
// [R20] slave only when rate matches playback
// [R21] status fields readable at any time
`ifndef SSL_REGS_VH
`define SSL_REGS_VH

// register word offsets
`define SSL_ADDR_W 4
`define SSL_OFS_CTRL 4'h0
`define SSL_OFS_PLAY_RATE 4'h1
`define SSL_OFS_REF_STAT 4'h4
`define SSL_OFS_LOCK_STAT 4'h5
`define SSL_OFS_SER_RATE 4'h6
`define SSL_OFS_BOOT_STAT 4'h7

// control register fields
`define SSL_CTRL_AUTO 0
`define SSL_CTRL_PREF_LO 1
`define SSL_CTRL_PREF_HI 2
`define SSL_CTRL_SER_IN_OPT 3
`define SSL_CTRL_SER_OUT_OPT 4
`define SSL_CTRL_DISC 5
`define SSL_CTRL_W 6
`define SSL_CTRL_RST 6'h00
`define SSL_PLAY_RST 8'h30

// reference codes, candidate index plus one, zero is internal clock
`define SSL_REF_MASTER 3'h0
`define SSL_REF_WORD 3'h1
`define SSL_REF_OPT 3'h2
`define SSL_REF_SYNC 3'h3
`define SSL_REF_SER 3'h4

// per input state
`define SSL_ST_NONE 2'h0
`define SSL_ST_LOCK 2'h1
`define SSL_ST_SYNC 2'h2

// link state
`define SSL_LINK_ERROR 2'h0
`define SSL_LINK_DETECT 2'h1
`define SSL_LINK_CONN 2'h2
`define SSL_LINK_DISC 2'h3

// rate measurement: gate of one millisecond gives kHz directly
`define SSL_CLK_MHZ 50
`define SSL_GATE_US 1000
`define SSL_GATE_CYC (`SSL_GATE_US * `SSL_CLK_MHZ)
`define SSL_RATE_TOL 8'h01

`endif

//--- ssl_sync2.v
// two flip-flop synchroniser for a group of level inputs
// assumes inputs are asynchronous to clk_i; only the second stage is read
`timescale 1ns/1ps
module ssl_sync2 #(
   parameter W = 1
)(
   input wire clk_i,
   input wire rst_i,
   input wire [W-1:0] d_i,
   output reg [W-1:0] q_o
);
   reg [W-1:0] meta;

   // first stage feeds nothing but the second
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta <= {W{1'b0}};
         q_o <= {W{1'b0}};
      end
      else
      begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule

//--- ssl_rate_meter.v
// counts rising edges of a synchronised frame strobe over a fixed gate
// assumes lvl_i is already in the clk_i domain; result in kHz, saturating
`timescale 1ns/1ps
module ssl_rate_meter #(
   parameter GATE_CYC = 50000,
   parameter CW = 17,
   parameter RW = 8
)(
   input wire clk_i,
   input wire rst_i,
   input wire lvl_i,
   output reg [RW-1:0] rate_o
);
   localparam [CW-1:0] GATE_LAST = GATE_CYC - 1;
   reg [CW-1:0] gate;
   reg [RW-1:0] cnt;
   reg prev;
   wire rise = lvl_i & ~prev;

   // gate window; a dead input reads zero after one window
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         gate <= {CW{1'b0}};
         cnt <= {RW{1'b0}};
         prev <= 1'b0;
         rate_o <= {RW{1'b0}};
      end
      else
      begin
         prev <= lvl_i;
         if (gate == GATE_LAST)
         begin
            gate <= {CW{1'b0}};
            rate_o <= cnt;
            cnt <= {{(RW-1){1'b0}}, rise};
         end
         else
         begin
            gate <= gate + 1'b1;
            if (rise && cnt != {RW{1'b1}})
               cnt <= cnt + 1'b1;
         end
      end
   end
endmodule

//--- ssl_properties.sv
// port checker for the sync source and link block
// assumes one clock domain and the map in ssl_regs.vh
`timescale 1ns/1ps
`include "ssl_regs.vh"
module ssl_properties (
   input wire clk_i,
   input wire rst_i,
   input wire [3:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rdata_o,
   input wire [3:0] in_lock_i,
   input wire [3:0] in_frame_i,
   input wire box_present_i,
   input wire box_loading_i,
   input wire update_failed_i,
   input wire warm_restart_i,
   input wire ser_tx_i,
   input wire opt_tx_i,
   input wire [2:0] clk_ref_o,
   input wire ser_rx_opt_o,
   input wire coax_out_o,
   input wire opt_out_o,
   input wire link_en_o,
   input wire backup_image_o
);
   reg [5:0] ctrl_s;
   reg [2:0] up;
   wire wr_ctrl;
   assign wr_ctrl = wr_i && (addr_i == `SSL_OFS_CTRL);
   // shadow control word and edges since reset, so no internal probes are needed
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_s <= 6'h00;
         up <= 3'h0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_s <= wdata_i[5:0];
         if (up != 3'h7)
            up <= up + 3'h1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_disc_set;
      wr_ctrl && wdata_i[`SSL_CTRL_DISC];
   endsequence
   // outputs are held zero at the first edge after reset, hence the up guard
   a_coax_copy: assert property (up >= 3'h2 |-> coax_out_o == $past(ser_tx_i))
      else $error("coax output does not follow serial data");
   a_opt_copy: assert property (up >= 3'h2 && $past(ctrl_s[4]) |->
      opt_out_o == $past(ser_tx_i)) else $error("optical output misses serial data");
   a_rx_select: assert property (wr_ctrl |-> ##2 ser_rx_opt_o == $past(wdata_i[3], 2))
      else $error("serial input select not applied");
   a_master_hold: assert property (up >= 3'h2 && !$past(ctrl_s[0]) |->
      clk_ref_o == `SSL_REF_MASTER) else $error("reference chosen in master mode");
   a_disc_drop: assert property (s_disc_set |-> ##2 (!link_en_o) [*4])
      else $error("link not stopped by disconnect");
   a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
      else $error("read data outside its cycle");
   // link state follows the control bit of the previous edge, so one cycle of history is enough
   a_disc_status: assert property (rd_i && addr_i == `SSL_OFS_LOCK_STAT && ctrl_s[5] &&
      $past(ctrl_s[5]) |=> rdata_o[9:8] == `SSL_LINK_DISC)
      else $error("link status not disconnected");
   // two synchroniser stages plus the output flop: the serial reference is gone three edges on
   a_ser_drop: assert property ($fell(in_lock_i[3]) |->
      ##3 clk_ref_o != `SSL_REF_SER) else $error("dead serial input kept as reference");
   a_image_hold: assert property (up == 3'h7 |-> $stable(backup_image_o))
      else $error("image choice changed without cold start");
endmodule
bind ssl_top ssl_properties ssl_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .in_lock_i(in_lock_i), .in_frame_i(in_frame_i), .box_present_i(box_present_i),
   .box_loading_i(box_loading_i), .update_failed_i(update_failed_i),
   .warm_restart_i(warm_restart_i), .ser_tx_i(ser_tx_i), .opt_tx_i(opt_tx_i),
   .clk_ref_o(clk_ref_o), .ser_rx_opt_o(ser_rx_opt_o), .coax_out_o(coax_out_o),
   .opt_out_o(opt_out_o), .link_en_o(link_en_o), .backup_image_o(backup_image_o));

//--- ssl_far_model.sv
// far side audio sources: lock levels and frame strobes per input
// assumes half periods in clk_i cycles, nonzero; a dead source holds its strobe low
`timescale 1ns/1ps
module ssl_far_model (
   input wire clk_i,
   input wire [3:0] en_i,
   input wire [15:0] hp_i,
   output wire [3:0] lock_o,
   output reg [3:0] frame_o
);
   integer k;
   reg [3:0] cnt [0:3];
   assign lock_o = en_i;
   // steady rates only; the bench changes a half period while sources stream, then settles
   always @(posedge clk_i)
   begin
      for (k = 0; k < 4; k = k + 1)
      begin
         if (!en_i[k])
         begin
            cnt[k] <= 4'h0;
            frame_o[k] <= 1'b0;
         end
         else if (cnt[k] + 4'h1 >= hp_i[4*k+:4])
         begin
            cnt[k] <= 4'h0;
            frame_o[k] <= !frame_o[k];
         end
         else
            cnt[k] <= cnt[k] + 4'h1;
      end
   end
endmodule

//--- tb.sv
// self-checking bench: register tasks, source and box stimulus
// assumes a 100-cycle gate, so a half period of 5 reads as rate 10
`timescale 1ns/1ps
`include "ssl_regs.vh"
module tb;
   reg clk_i, rst_i, wr_i, rd_i, present, loading, failed, warm, ser_tx, opt_tx;
   reg [3:0] addr_i, en;
   reg [31:0] wdata_i, r;
   reg [15:0] hp;
   wire [31:0] rdata_o;
   wire [3:0] lock, frame;
   wire [2:0] clk_ref_o;
   wire rx_opt, coax, opt_out, link_en, backup;
   integer n_errors, total_checks, k;
   ssl_top #(.GATE_CYC(100)) ssl_top_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .in_lock_i(lock),
      .in_frame_i(frame), .box_present_i(present), .box_loading_i(loading),
      .update_failed_i(failed), .warm_restart_i(warm), .ser_tx_i(ser_tx),
      .opt_tx_i(opt_tx), .clk_ref_o(clk_ref_o), .ser_rx_opt_o(rx_opt), .coax_out_o(coax),
      .opt_out_o(opt_out), .link_en_o(link_en), .backup_image_o(backup));
   ssl_far_model ssl_far_model_inst (.clk_i(clk_i), .en_i(en), .hp_i(hp), .lock_o(lock),
      .frame_o(frame));
   task chk(input [31:0] got, input [31:0] exp);
   begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task wr(input [3:0] a, input [31:0] d);
   begin
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   end
   endtask
   // read data stand only in the cycle after the strobe, so sample just past that edge
   task rd(input [3:0] a);
   begin
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      r = rdata_o;
   end
   endtask
   // rates need a full gate or more after any source change
   task settle;
      repeat (350) @(posedge clk_i);
   endtask
   task tally_and_finish;
   begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // a hang counts as a mismatch
   initial
   begin
      #1_000_000;
      n_errors = n_errors + 1;
      tally_and_finish;
   end
   initial
   begin
      n_errors = 0;
      total_checks = 0;
      {rst_i, wr_i, rd_i, present, loading, failed, warm, ser_tx, opt_tx} = 9'h100;
      addr_i = 4'h0;
      wdata_i = 32'h0000_0000;
      en = 4'h0;
      hp = 16'h5555;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      present <= 1'b1;
      rd(`SSL_OFS_PLAY_RATE);
      chk(r, 32'h0000_0030);
      rd(4'h3);
      chk(r, 32'h0000_0000);
      rd(`SSL_OFS_BOOT_STAT);
      chk(r, 32'h0000_0002);
      $display("reset values done");
      wr(`SSL_OFS_PLAY_RATE, 32'h0000_000A);
      en <= 4'hF;
      settle;
      rd(`SSL_OFS_REF_STAT);
      chk(r, 32'h0000_0A00);
      rd(`SSL_OFS_SER_RATE);
      chk(r >= 9 && r <= 11, 1);
      for (k = 0; k < 4; k = k + 1)
      begin
         wr(`SSL_OFS_CTRL, 2 * k + 1);
         repeat (10) @(posedge clk_i);
         chk(clk_ref_o, k + 1);
         rd(`SSL_OFS_REF_STAT);
         chk(r[2:0], k + 1);
      end
      // serial is the reference here; losing it must wrap the scan round to word clock
      en <= 4'h7;
      repeat (10) @(posedge clk_i);
      chk(clk_ref_o, `SSL_REF_WORD);
      $display("preferred reference done");
      wr(`SSL_OFS_CTRL, 32'h0000_0001);
      en <= 4'hE;
      settle;
      chk(clk_ref_o, `SSL_REF_OPT);
      hp <= 16'h5525;
      settle;
      chk(clk_ref_o, `SSL_REF_SYNC);
      en <= 4'h0;
      settle;
      chk(clk_ref_o, `SSL_REF_MASTER);
      en <= 4'h3;
      settle;
      rd(`SSL_OFS_LOCK_STAT);
      chk(r, 32'h0000_0206);
      $display("fallback done");
      loading <= 1'b1;
      repeat (10) @(posedge clk_i);
      rd(`SSL_OFS_LOCK_STAT);
      chk(r, 32'h0000_0106);
      present <= 1'b0;
      repeat (10) @(posedge clk_i);
      rd(`SSL_OFS_LOCK_STAT);
      chk(r, 32'h0000_0006);
      wr(`SSL_OFS_CTRL, 32'h0000_0021);
      repeat (3) @(posedge clk_i);
      chk(link_en, 0);
      rd(`SSL_OFS_LOCK_STAT);
      chk(r[9:8], `SSL_LINK_DISC);
      wr(`SSL_OFS_CTRL, 32'h0000_0018);
      {present, loading, ser_tx, opt_tx} <= 4'hA;
      repeat (3) @(posedge clk_i);
      chk({link_en, rx_opt, coax, opt_out}, 4'hF);
      wr(`SSL_OFS_CTRL, 32'h0000_0000);
      repeat (3) @(posedge clk_i);
      chk({rx_opt, coax, opt_out}, 3'h2);
      $display("link and routing done");
      warm <= 1'b1;
      @(posedge clk_i);
      warm <= 1'b0;
      failed <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk(backup, 0);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk(backup, 1);
      rd(`SSL_OFS_BOOT_STAT);
      chk(r, 32'h0000_0003);
      warm <= 1'b1;
      @(posedge clk_i);
      warm <= 1'b0;
      failed <= 1'b0;
      repeat (10) @(posedge clk_i);
      chk(backup, 1);
      $display("image choice done");
      tally_and_finish;
   end
endmodule
